// file: sclp_cfg.svh
// timing counts and field constants for the clock-enable low-power block
`ifndef SCLP_CFG_SVH
`define SCLP_CFG_SVH

`define SCLP_CLK_PERIOD_PS      4000
`define SCLP_REFRESH_CYCLE_PS   60000
// least time rounds up to whole cycles
`define SCLP_REFRESH_CYCLES ((`SCLP_REFRESH_CYCLE_PS + `SCLP_CLK_PERIOD_PS - 1) / `SCLP_CLK_PERIOD_PS)
`define SCLP_CNT_W              8
`define SCLP_NUM_BANKS          4
`define SCLP_BANK_W             2

`endif

// file: sclp_cmd_dec.sv
// command pin decoder
`timescale 1ns/1ps
module sclp_cmd_dec
    import sclp_pkg::*;
(
    input  wire logic i_cs_n,
    input  wire logic i_ras_n,
    input  wire logic i_cas_n,
    input  wire logic i_we_n,
    sclp_cmd_if.src   cmd_out
);
    always_comb begin
        cmd_out.is_exit_ok = i_cs_n | (i_ras_n & i_cas_n & i_we_n);
        if (i_cs_n) begin
            cmd_out.cmd = SCLP_CMD_DESELECT;
        end else begin
            unique case ({i_ras_n, i_cas_n, i_we_n})
                3'b111: cmd_out.cmd = SCLP_CMD_NOP;
                3'b110: cmd_out.cmd = SCLP_CMD_BURST_STOP;
                3'b101: cmd_out.cmd = SCLP_CMD_READ;
                3'b100: cmd_out.cmd = SCLP_CMD_WRITE;
                3'b011: cmd_out.cmd = SCLP_CMD_ACTIVATE;
                3'b010: cmd_out.cmd = SCLP_CMD_PRECHARGE;
                3'b001: cmd_out.cmd = SCLP_CMD_REFRESH;
                3'b000: cmd_out.cmd = SCLP_CMD_MODE_REG;
            endcase
        end
    end
endmodule // sclp_cmd_dec

// file: sclp_cmd_if.sv
// decoded command bundle passed from the decoder to the low-power control
`timescale 1ns/1ps
interface sclp_cmd_if;
    import sclp_pkg::*;
    sclp_cmd_e cmd;
    logic      is_exit_ok;
    modport src (output cmd, output is_exit_ok);
    modport dst (input cmd, input is_exit_ok);
endinterface

// file: sclp_ctrl_model.sv
// command-pin model of the external memory controller
`timescale 1ns/1ps
module sclp_ctrl_model
    import sclp_pkg::*;
(
    input  wire logic      i_clk_sys,
    input  wire sclp_cmd_e i_req,
    output logic           o_cs_n,
    output logic           o_ras_n,
    output logic           o_cas_n,
    output logic           o_we_n
);
    logic tog;
    // deselected strobes toggle so a stale level is never mistaken for a command
    // toggled on the falling edge so the pins are settled at the sampling edge
    always_ff @(negedge i_clk_sys) tog <= (tog === 1'b1) ? 1'b0 : 1'b1;
    // low-power exit only with nop or deselect; power-down entry also needs all banks idle, self-refresh entry uses refresh
    always_comb begin
        {o_cs_n, o_ras_n, o_cas_n, o_we_n} = (i_req == SCLP_CMD_DESELECT) ?
            {1'b1, {3{tog}}} : {1'b0, 3'(4'h8 - i_req)};
    end
endmodule // sclp_ctrl_model

// file: sclp_lowpower_ctrl.sv
// clock-enable, power-down and self-refresh control of the dram core
`timescale 1ns/1ps
`include "sclp_cfg.svh"

// Contract
// - self-refresh exit waits refresh cycle time, then idle
// - power-down exit returns straight to idle
// - clock enable low twice: ignore commands, hold
// - clock enable high twice: normal command decode
// - rising clock enable re-enables inputs; setup before commands (o_inputs_enabled waits for active mode, past the self-refresh exit wait)
// - legality judged per bank selected
// - precharge to idle bank acts as no-op
module sclp_lowpower_ctrl
    import sclp_pkg::*;
#(
    parameter int NUM_BANKS  = `SCLP_NUM_BANKS,
    parameter int REF_CYCLES = `SCLP_REFRESH_CYCLES
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_nrst,
    input  wire logic                 i_clk_gate,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_ras_n,
    input  wire logic                 i_cas_n,
    input  wire logic                 i_we_n,
    input  wire logic [`SCLP_BANK_W-1:0] i_bank_select_field,
    input  wire logic                 i_auto_precharge_flag,
    input  wire logic [NUM_BANKS-1:0] i_bank_idle,
    input  wire logic [NUM_BANKS-1:0] i_bank_precharging,
    output logic                      o_cmd_valid,
    output sclp_cmd_e                 o_cmd,
    output logic [NUM_BANKS-1:0]      o_precharge_banks,
    output logic                      o_power_down,
    output logic                      o_self_refresh,
    output logic                      o_inputs_enabled,
    output logic                      o_illegal
);
    //--------------------------------------------------------------
    // state
    //--------------------------------------------------------------
    typedef struct packed {
        logic                    gate_prev;
        sclp_mode_e              mode;
        logic [`SCLP_CNT_W-1:0]  cnt;
        logic                    cmd_valid;
        sclp_cmd_e               cmd;
        logic [NUM_BANKS-1:0]    pre_banks;
        logic                    illegal;
    } sclp_state_s;

    sclp_state_s st;
    sclp_state_s next_st;

    sclp_cmd_if cmd_bus ();

    sclp_cmd_dec u_dec (
        .i_cs_n  (i_cs_n),
        .i_ras_n (i_ras_n),
        .i_cas_n (i_cas_n),
        .i_we_n  (i_we_n),
        .cmd_out (cmd_bus.src)
    );

    logic                 all_idle;
    logic                 any_rw_bad;
    logic                 any_act_bad;
    sclp_cmd_e            dec_cmd;
    logic                 dec_exit_ok;
    logic [NUM_BANKS-1:0] sel_onehot;
    logic [NUM_BANKS-1:0] pre_target;
    logic [NUM_BANKS-1:0] rw_bad;
    logic [NUM_BANKS-1:0] act_bad;

    // decoded command read once here so the state logic sees plain signals
    assign dec_cmd     = cmd_bus.cmd;
    assign dec_exit_ok = cmd_bus.is_exit_ok;
    assign all_idle    = &i_bank_idle;
    assign any_rw_bad  = |rw_bad;
    assign any_act_bad = |act_bad;

    //--------------------------------------------------------------
    // per-bank selection and legality
    //--------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < NUM_BANKS; b++) begin : g_bank
            assign sel_onehot[b] = (i_bank_select_field == `SCLP_BANK_W'(b));
            // idle or precharging bank treats precharge as a no-op
            assign pre_target[b] = (i_auto_precharge_flag | sel_onehot[b])
                                   & ~i_bank_idle[b] & ~i_bank_precharging[b];
            // only the addressed bank's own state decides legality
            assign rw_bad[b]     = sel_onehot[b] & i_bank_idle[b];
            assign act_bad[b]    = sel_onehot[b] & ~i_bank_idle[b];
        end
    endgenerate

    //--------------------------------------------------------------
    // reset value
    //--------------------------------------------------------------
    // gate_prev starts low so no command is decoded on the first edge
    localparam sclp_state_s st_reset = '{
        gate_prev: 1'b0,
        mode:      SCLP_ACTIVE,
        cnt:       '0,
        cmd_valid: 1'b0,
        cmd:       SCLP_CMD_DESELECT,
        pre_banks: '0,
        illegal:   1'b0
    };

    //--------------------------------------------------------------
    // next state
    //--------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.gate_prev = i_clk_gate;
        next_st.cmd_valid = 1'b0;
        next_st.cmd       = dec_cmd;
        next_st.pre_banks = '0;
        next_st.illegal   = 1'b0;
        unique case (st.mode)
            SCLP_ACTIVE: begin
                if (st.gate_prev && i_clk_gate) begin
                    // full decode only while enable stays high
                    next_st.cmd_valid = 1'b1;
                    if (dec_cmd == SCLP_CMD_PRECHARGE) begin
                        next_st.pre_banks = pre_target;
                    end
                    // global commands need every bank idle
                    if ((dec_cmd == SCLP_CMD_REFRESH ||
                         dec_cmd == SCLP_CMD_MODE_REG) && !all_idle) begin
                        next_st.illegal = 1'b1;
                    end
                    // column commands and burst stop need an open row in that bank
                    if ((dec_cmd == SCLP_CMD_READ ||
                         dec_cmd == SCLP_CMD_WRITE ||
                         dec_cmd == SCLP_CMD_BURST_STOP) && any_rw_bad) begin
                        next_st.illegal = 1'b1;
                    end
                    // a second activate to a busy bank would lose its open row
                    if (dec_cmd == SCLP_CMD_ACTIVATE && any_act_bad) begin
                        next_st.illegal = 1'b1;
                    end
                end else if (st.gate_prev && !i_clk_gate) begin
                    if (!all_idle) begin
                        next_st.illegal = 1'b1;
                    end else if (dec_exit_ok) begin
                        next_st.mode = SCLP_POWER_DOWN;
                    end else if (dec_cmd == SCLP_CMD_REFRESH) begin
                        next_st.mode = SCLP_SELF_REFRESH;
                    end else begin
                        next_st.illegal = 1'b1;
                    end
                end
                // first edge with enable back high: history not yet known, no decode
            end
            SCLP_POWER_DOWN: begin
                if (!st.gate_prev && i_clk_gate) begin
                    if (dec_exit_ok) begin
                        next_st.mode = SCLP_ACTIVE;
                    end else begin
                        next_st.illegal = 1'b1;
                    end
                end
                // low twice: hold, commands ignored
            end
            SCLP_SELF_REFRESH: begin
                if (!st.gate_prev && i_clk_gate) begin
                    if (dec_exit_ok) begin
                        next_st.mode = SCLP_SR_EXIT;
                        next_st.cnt  = `SCLP_CNT_W'(REF_CYCLES - 1);
                    end else begin
                        next_st.illegal = 1'b1;
                    end
                end
                // low twice: refresh runs on internally, commands ignored
            end
            SCLP_SR_EXIT: begin
                // commands during refresh recovery are not decoded
                if (st.cnt == '0) begin
                    next_st.mode = SCLP_ACTIVE;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
        endcase
    end

    //--------------------------------------------------------------
    // registers
    //--------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= st_reset;
        end else begin
            st <= next_st;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign o_cmd_valid       = st.cmd_valid;
    assign o_cmd             = st.cmd;
    assign o_precharge_banks = st.pre_banks;
    assign o_illegal         = st.illegal;
    assign o_power_down      = (st.mode == SCLP_POWER_DOWN);
    assign o_self_refresh    = (st.mode == SCLP_SELF_REFRESH) || (st.mode == SCLP_SR_EXIT);
    // enable gates inputs combinationally in active mode; leaving low power, they return with the registered mode
    assign o_inputs_enabled  = i_clk_gate & (st.mode == SCLP_ACTIVE);

endmodule // sclp_lowpower_ctrl

// file: sclp_lowpower_ctrl_sva.sv
// assertions for the clock-enable low-power block
`timescale 1ns/1ps
module sclp_lowpower_ctrl_sva
    import sclp_pkg::*;
#(
    parameter int NUM_BANKS  = 4,
    parameter int REF_CYCLES = 3
) (
    input wire logic                 i_clk_sys,
    input wire logic                 i_nrst,
    input wire logic                 i_clk_gate,
    input wire logic                 i_cs_n,
    input wire logic                 i_ras_n,
    input wire logic                 i_cas_n,
    input wire logic                 i_we_n,
    input wire logic [1:0]           i_bank_select_field,
    input wire logic                 i_auto_precharge_flag,
    input wire logic [NUM_BANKS-1:0] i_bank_idle,
    input wire logic [NUM_BANKS-1:0] i_bank_precharging,
    input wire logic                 o_cmd_valid,
    input wire sclp_cmd_e            o_cmd,
    input wire logic [NUM_BANKS-1:0] o_precharge_banks,
    input wire logic                 o_power_down,
    input wire logic                 o_self_refresh,
    input wire logic                 o_inputs_enabled,
    input wire logic                 o_illegal
);
    logic                 gp;
    logic [NUM_BANKS-1:0] exp_pre;
    wire nop = i_cs_n | (i_ras_n & i_cas_n & i_we_n);
    wire act = !o_power_down && !o_self_refresh;
    wire run = gp && i_clk_gate && act;
    wire ent = gp && !i_clk_gate && act && (&i_bank_idle);
    wire lv  = !gp && i_clk_gate && nop;
    // mask is computed every edge so it is ready when the pulse lands
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            gp      <= 1'b0;
            exp_pre <= '0;
        end else begin
            gp      <= i_clk_gate;
            exp_pre <= (i_auto_precharge_flag ? '1 : NUM_BANKS'(1) << i_bank_select_field)
                & ~(i_bank_idle | i_bank_precharging);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    a_sr_exit_wait: assert property (
        o_self_refresh && lv |-> ##REF_CYCLES o_self_refresh ##1 !o_self_refresh) else $error("sr exit");
    a_pd_exit_idle: assert property (
        o_power_down && lv |=> !o_power_down) else $error("pd exit");
    a_low_hold: assert property (
        !gp && !i_clk_gate && !act |=> !o_cmd_valid && $stable(o_power_down)) else $error("hold");
    a_read_decode: assert property (
        run && !i_cs_n && i_ras_n && !i_cas_n && i_we_n |=> o_cmd_valid && o_cmd == SCLP_CMD_READ)
        else $error("read decode");
    a_inputs_gate: assert property (
        o_inputs_enabled == (i_clk_gate && act)) else $error("inputs enable");
    a_pre_mask: assert property (
        run && !i_cs_n && !i_ras_n && i_cas_n && !i_we_n |=> o_precharge_banks == exp_pre)
        else $error("precharge mask");
    a_pd_entry: assert property (
        ent && nop |=> o_power_down) else $error("pd entry");
    a_sr_entry: assert property (
        ent && !i_cs_n && !i_ras_n && !i_cas_n && i_we_n |=> o_self_refresh) else $error("sr entry");
    a_refresh_busy: assert property (
        run && !i_cs_n && !i_ras_n && !i_cas_n && i_we_n && !(&i_bank_idle) |=> o_illegal)
        else $error("refresh with busy bank");
    a_bad_exit: assert property (
        o_power_down && !gp && i_clk_gate && !nop |=> o_illegal && o_power_down)
        else $error("bad exit");
endmodule // sclp_lowpower_ctrl_sva
bind sclp_lowpower_ctrl sclp_lowpower_ctrl_sva #(.NUM_BANKS(NUM_BANKS), .REF_CYCLES(REF_CYCLES))
    i_sclp_lowpower_ctrl_sva (.*);

// file: sclp_pkg.sv
// types shared by the clock-enable low-power block
package sclp_pkg;

    typedef enum logic [1:0] {
        SCLP_ACTIVE,
        SCLP_POWER_DOWN,
        SCLP_SELF_REFRESH,
        SCLP_SR_EXIT
    } sclp_mode_e;

    typedef enum logic [3:0] {
        SCLP_CMD_DESELECT,
        SCLP_CMD_NOP,
        SCLP_CMD_BURST_STOP,
        SCLP_CMD_READ,
        SCLP_CMD_WRITE,
        SCLP_CMD_ACTIVATE,
        SCLP_CMD_PRECHARGE,
        SCLP_CMD_REFRESH,
        SCLP_CMD_MODE_REG
    } sclp_cmd_e;

endpackage

// file: sdram_clock_enable_lowpower_control_test.sv
// self-checking bench for the clock-enable low-power block
`timescale 1ns/1ps
module sdram_clock_enable_lowpower_control_test;
    import sclp_pkg::*;
    localparam int NB  = 4;
    localparam int REF = 3;
    logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_clk_gate = 1'b1, i_auto_precharge_flag = 1'b0;
    logic i_cs_n, i_ras_n, i_cas_n, i_we_n, o_cmd_valid, o_power_down, o_self_refresh;
    logic o_inputs_enabled, o_illegal;
    logic [1:0]    i_bank_select_field = 2'h0;
    logic [NB-1:0] i_bank_idle = '1, i_bank_precharging = '0, o_precharge_banks;
    sclp_cmd_e     req = SCLP_CMD_NOP, o_cmd;
    int            error_cnt = 0, comparisons = 0, seed = 32'h9739;
    initial forever #2 i_clk_sys = ~i_clk_sys;
    sclp_ctrl_model i_sclp_ctrl_model (.i_clk_sys, .i_req(req), .o_cs_n(i_cs_n),
        .o_ras_n(i_ras_n), .o_cas_n(i_cas_n), .o_we_n(i_we_n));
    sclp_lowpower_ctrl #(.NUM_BANKS(NB), .REF_CYCLES(REF)) i_sclp_lowpower_ctrl (.*);
    // inputs change at the falling edge, outputs are read just after the rising one
    task automatic step(input logic g, input sclp_cmd_e c, input bit rnd);
        @(negedge i_clk_sys);
        i_clk_gate = g;
        req = c;
        if (rnd) {i_bank_select_field, i_auto_precharge_flag, i_bank_idle,
            i_bank_precharging} = 11'($random(seed));
        else {i_bank_idle, i_bank_precharging} = {{NB{1'b1}}, {NB{1'b0}}};
        @(posedge i_clk_sys);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [NB-1:0] exp_mask();
        return (i_auto_precharge_flag ? {NB{1'b1}} : NB'(1) << i_bank_select_field)
            & ~(i_bank_idle | i_bank_precharging);
    endfunction
    task automatic test_done();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_nrst = 1'b1;
        step(1, SCLP_CMD_NOP, 0);
        step(1, SCLP_CMD_NOP, 0);
        // random burst stop through mode access, gate high throughout
        for (int k = 0; k < 80; k++) begin
            step(1, sclp_cmd_e'(2 + $unsigned($random(seed)) % 7), 1);
            chk("cmd", req, o_cmd);
            chk("valid", 1, o_cmd_valid);
            if (req == SCLP_CMD_PRECHARGE) chk("mask", exp_mask(), o_precharge_banks);
        end
        step(0, SCLP_CMD_NOP, 0);
        chk("pd_entry", 1, o_power_down);
        repeat (3) begin
            step(0, SCLP_CMD_READ, 0);
            chk("pd_hold", 1, o_power_down);
            chk("pd_quiet", 0, o_cmd_valid);
        end
        step(1, SCLP_CMD_READ, 0);
        chk("bad_exit", 1, o_illegal);
        step(0, SCLP_CMD_NOP, 0);
        chk("pd_stay", 1, o_power_down);
        step(1, SCLP_CMD_DESELECT, 0);
        chk("pd_exit", 0, o_power_down);
        step(1, SCLP_CMD_READ, 0);
        chk("first_cmd", SCLP_CMD_READ, o_cmd);
        step(0, SCLP_CMD_REFRESH, 0);
        chk("sr_entry", 1, o_self_refresh);
        step(0, SCLP_CMD_WRITE, 0);
        chk("sr_hold", 1, o_self_refresh);
        step(1, SCLP_CMD_NOP, 0);
        for (int k = 0; k < REF; k++) begin
            chk("sr_wait", 1, o_self_refresh);
            step(1, SCLP_CMD_NOP, 0);
        end
        chk("sr_done", 0, o_self_refresh);
        chk("inputs_on", 1, o_inputs_enabled);
        test_done();
    end
endmodule // sdram_clock_enable_lowpower_control_test
